// [design/jump_and_increment_execution.sv]
// Execution unit for the far jump and add-one instructions behind a Wishbone register port
`timescale 1ns/10ps
// Overview of operation
// - Far jump loads its 20-bit literal into program counter bits 20:1, bit 0 zero.
// - Far jump reaches the full 2-Mbyte program space when its second word carries the F prefix.
// - Far jump uses two words and two cycles; the second cycle does nothing.
// - Add-one is recognised by opcode 001010, then destination, access, 8-bit address.
// - Add-one writes sum to accumulator when destination is 0, else to the register.
// - Access bit 0 uses the access bank, 1 uses the bank pointer.
// - Add-one updates carry, half carry, negative, overflow and zero; FF wraps to 00.
module jump_and_increment_execution (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       clk_en,
    // Register port
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [exec_pkg::WB_AW-1:0] wb_adr_i,
    input  wire logic [exec_pkg::WB_DW-1:0] wb_dat_i,
    output wire logic [exec_pkg::WB_DW-1:0] wb_dat_o,
    output wire logic                       wb_ack_o,
    // Data memory side
    input  wire logic [3:0]                 bank_pointer,
    input  wire logic [7:0]                 dmem_rdata,
    output wire logic [11:0]                dmem_addr,
    output wire logic [7:0]                 dmem_wdata,
    output wire logic                       dmem_we,
    // Core state
    output wire logic [20:0]                prog_counter,
    output wire logic [7:0]                 accumulator,
    output wire logic                       carry_flag,
    output wire logic                       half_byte_flag,
    output wire logic                       zero_flag,
    output wire logic                       arith_wrap_flag,
    output wire logic                       neg_flag,
    output wire logic                       busy
);
    import exec_pkg::*;

    typedef struct packed {
        // Sequencer
        exec_state_t        st;
        logic [1:0]         phase;
        // Instruction words and operands
        logic [15:0]        instr;
        logic [11:0]        khi;
        logic [7:0]         klo;
        logic [7:0]         opnd;
        // Architectural state
        logic [20:0]        pc;
        logic [7:0]         acc;
        logic [FLG_W-1:0]   flg;
        // Data memory strobes
        logic [11:0]        dmem_addr;
        logic [7:0]         dmem_wdata;
        logic               dmem_we;
        // Bus answer and status
        logic               ack;
        logic [WB_DW-1:0]   dat_o;
        logic               refused;
        logic               busy;
    } state_t;

    // State register and its next value
    state_t             cur;
    state_t             next_cur;
    // Incrementer results
    logic [7:0]         inc_sum;
    logic [FLG_W-1:0]   inc_flags;
    // Bus decode
    logic               bus_req;
    logic               bus_wr;
    logic               instr_wr;
    // Instruction fields
    logic               is_jump;
    logic               is_add;
    logic               dest_reg;
    logic               use_bank_ptr;
    logic [7:0]         reg_off;
    logic [3:0]         eff_bank;
    logic [WB_DW-1:0]   status_word;
    logic [WB_DW-1:0]   pc_merged;

    // Merge write data into an old word by byte lanes
    function automatic logic [WB_DW-1:0] lane_merge(input logic [WB_DW-1:0] old_w,
                                                    input logic [WB_DW-1:0] new_w,
                                                    input logic [3:0]       sel);
        logic [WB_DW-1:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Incrementer works on the operand captured in Q2
    add_one_unit u_add_one (
        .operand (cur.opnd),
        .sum     (inc_sum),
        .flags   (inc_flags)
    );

    // Byte-lane merge of a bus write into the zero-extended program counter
    assign pc_merged = lane_merge({11'h000, cur.pc}, wb_dat_i, wb_sel_i);

    // Instruction field decode
    assign is_jump      = (cur.instr[15:8] == FAR_JUMP_W1_OP);
    assign is_add       = (cur.instr[15:10] == ADD_ONE_OP);
    assign dest_reg     = cur.instr[OP_DEST_BIT];
    assign use_bank_ptr = cur.instr[OP_ACCESS_BIT];
    assign reg_off      = cur.instr[7:0];

    // Bank pointer is bypassed when the access bit is clear
    assign eff_bank = use_bank_ptr ? bank_pointer :
                      (reg_off[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK);

    // Bus strobes: a request completes on the edge where ack is high
    assign bus_req  = wb_cyc_i & wb_stb_i;
    assign bus_wr   = bus_req & cur.ack & wb_we_i;
    assign instr_wr = bus_wr & (wb_adr_i == OFS_INSTR) & (wb_sel_i[1:0] == 2'h3);

    // Status word seen by software
    always_comb begin
        status_word = '0;
        status_word[FLG_W-1:0]  = cur.flg;
        status_word[STS_BUSY]    = cur.busy;
        status_word[STS_WAIT_HI] = (cur.st == ST_WAIT_HI);
        status_word[STS_REFUSED] = cur.refused;
    end

    // Next-state logic for bus, sequencer and datapath
    always_comb begin
        next_cur = cur;
        next_cur.dmem_we = 1'b0;
        next_cur.ack     = bus_req & ~cur.ack;

        // Read data prepared with ack; unmapped offsets read zero
        unique case (wb_adr_i)
            OFS_INSTR:  next_cur.dat_o = {16'h0000, cur.instr};
            OFS_PC:     next_cur.dat_o = {11'h000, cur.pc};
            OFS_ACC:    next_cur.dat_o = {24'h000000, cur.acc};
            OFS_STATUS: next_cur.dat_o = status_word;
            default:    next_cur.dat_o = '0;
        endcase

        // Software writes to program counter, accumulator and status
        if (bus_wr && wb_adr_i == OFS_PC) begin
            next_cur.pc = pc_merged[20:0];
            next_cur.pc[0] = 1'b0;
        end
        if (bus_wr && wb_adr_i == OFS_ACC && wb_sel_i[0]) begin
            next_cur.acc = wb_dat_i[7:0];
        end
        if (bus_wr && wb_adr_i == OFS_STATUS && wb_sel_i[0]) begin
            if (wb_dat_i[STS_REFUSED]) begin
                next_cur.refused = 1'b0;
            end
            next_cur.flg = wb_dat_i[FLG_W-1:0];
        end

        // Sequencer
        unique case (cur.st)
            ST_IDLE: begin
                if (instr_wr) begin
                    next_cur.instr = wb_dat_i[15:0];
                    next_cur.phase = PH_Q1;
                    if (wb_dat_i[15:8] == FAR_JUMP_W1_OP) begin
                        next_cur.st = ST_WAIT_HI;
                    end else begin
                        next_cur.st = ST_EXEC;
                    end
                    next_cur.busy = 1'b1;
                end
            end

            ST_WAIT_HI: begin
                // Second word must carry the all-ones prefix, else the jump is dropped
                if (instr_wr) begin
                    if (wb_dat_i[15:12] == FAR_JUMP_W2_PFX) begin
                        next_cur.khi = wb_dat_i[11:0];
                        next_cur.st  = ST_EXEC;
                    end else begin
                        next_cur.st      = ST_IDLE;
                        next_cur.busy    = 1'b0;
                        next_cur.refused = 1'b1;
                    end
                end
            end

            ST_EXEC: begin
                next_cur.phase = cur.phase + 2'h1;
                unique case (cur.phase)
                    PH_Q1: begin
                        // Decode and present the register address
                        if (is_add) begin
                            next_cur.dmem_addr = {eff_bank, reg_off};
                        end
                    end

                    PH_Q2: begin
                        // Read the register, or latch the low literal
                        if (is_add) begin
                            next_cur.opnd = dmem_rdata;
                        end
                        if (is_jump) begin
                            next_cur.klo = cur.instr[7:0];
                        end
                    end

                    PH_Q3: begin
                        // Process data; register write strobe lands in Q4
                        if (is_add) begin
                            next_cur.dmem_wdata = inc_sum;
                            next_cur.dmem_we    = dest_reg;
                        end
                    end

                    PH_Q4: begin
                        // Write destination, or load the program counter
                        if (is_add) begin
                            if (!dest_reg) begin
                                next_cur.acc = inc_sum;
                            end
                            next_cur.flg = inc_flags;
                        end
                        if (is_jump) begin
                            next_cur.pc = {cur.khi, cur.klo, 1'b0};
                            next_cur.st = ST_FLUSH;
                        end else begin
                            next_cur.st   = ST_IDLE;
                            next_cur.busy = 1'b0;
                        end
                    end
                endcase
            end

            ST_FLUSH: begin
                // Idle second cycle while the target is fetched
                next_cur.phase = cur.phase + 2'h1;
                if (cur.phase == PH_Q4) begin
                    next_cur.st   = ST_IDLE;
                    next_cur.busy = 1'b0;
                end
            end
        endcase

        // Instruction writes while executing are dropped; set beats a same-cycle clear
        if (instr_wr && (cur.st == ST_EXEC || cur.st == ST_FLUSH)) begin
            next_cur.refused = 1'b1;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur.st         <= ST_IDLE;
            cur.phase      <= PH_Q1;
            cur.instr      <= 16'h0000;
            cur.khi        <= 12'h000;
            cur.klo        <= 8'h00;
            cur.opnd       <= 8'h00;
            cur.pc         <= RST_PC;
            cur.acc        <= RST_ACC;
            cur.flg        <= RST_FLAGS;
            cur.dmem_addr  <= 12'h000;
            cur.dmem_wdata <= 8'h00;
            cur.dmem_we    <= 1'b0;
            cur.ack        <= 1'b0;
            cur.dat_o      <= '0;
            cur.refused    <= 1'b0;
            cur.busy       <= 1'b0;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o        = cur.dat_o;
    assign wb_ack_o        = cur.ack;

    // Data memory strobes
    assign dmem_addr       = cur.dmem_addr;
    assign dmem_wdata      = cur.dmem_wdata;
    assign dmem_we         = cur.dmem_we;

    // Architectural state and flags
    assign prog_counter    = cur.pc;
    assign accumulator     = cur.acc;
    assign carry_flag      = cur.flg[FLG_C];
    assign half_byte_flag  = cur.flg[FLG_DC];
    assign zero_flag       = cur.flg[FLG_Z];
    assign arith_wrap_flag = cur.flg[FLG_OV];
    assign neg_flag        = cur.flg[FLG_N];

    // Sequencer activity
    assign busy            = cur.busy;
endmodule

// [design/exec_pkg.sv]
// Shared constants and types for the jump and add-one execution unit
package exec_pkg;

    // Wishbone geometry
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_INSTR  = 8'h00;
    localparam logic [7:0] OFS_PC     = 8'h04;
    localparam logic [7:0] OFS_ACC    = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // Flag bit positions inside the flag vector and the status register
    localparam int FLG_C  = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N  = 4;
    localparam int FLG_W  = 5;

    // Status register fields above the flags
    localparam int STS_BUSY    = 5;
    localparam int STS_WAIT_HI = 6;
    localparam int STS_REFUSED = 7;

    // Reset values
    localparam logic [20:0] RST_PC    = 21'h000000;
    localparam logic [7:0]  RST_ACC   = 8'h00;
    localparam logic [4:0]  RST_FLAGS = 5'h00;

    // Instruction encodings
    localparam logic [7:0] FAR_JUMP_W1_OP  = 8'hEF;
    localparam logic [3:0] FAR_JUMP_W2_PFX = 4'hF;
    localparam logic [5:0] ADD_ONE_OP      = 6'h0A;
    localparam int         OP_DEST_BIT     = 9;
    localparam int         OP_ACCESS_BIT   = 8;

    // Access bank halves: low addresses map to bank 0, high ones to the top bank
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

    // Quarter phases of one instruction cycle
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_HI,
        ST_EXEC,
        ST_FLUSH
    } exec_state_t;

endpackage

// [design/add_one_unit.sv]
// Byte incrementer with arithmetic flag generation
`timescale 1ns/10ps
module add_one_unit (
    input  wire logic [7:0]                 operand,
    output wire logic [7:0]                 sum,
    output wire logic [exec_pkg::FLG_W-1:0] flags
);
    import exec_pkg::*;

    logic [8:0] wide;

    // Nine-bit sum keeps the carry out of bit 7
    assign wide = {1'b0, operand} + 9'h001;
    assign sum  = wide[7:0];

    // All-ones wraps to zero with carry and half carry set
    assign flags[FLG_C]  = wide[8];
    assign flags[FLG_DC] = (operand[3:0] == 4'hF);
    assign flags[FLG_Z]  = (wide[7:0] == 8'h00);
    assign flags[FLG_OV] = (operand == 8'h7F);
    assign flags[FLG_N]  = wide[7];
endmodule

// [verif/exec_asserts.sv]
// Port-level checker for the jump and add-one execution unit
`timescale 1ns/10ps
module exec_asserts (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [7:0]  dmem_rdata,
    input wire logic [11:0] dmem_addr,
    input wire logic [7:0]  dmem_wdata,
    input wire logic        dmem_we,
    input wire logic [20:0] prog_counter,
    input wire logic        carry_flag,
    input wire logic        half_byte_flag,
    input wire logic        zero_flag,
    input wire logic        neg_flag,
    input wire logic        busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Bus answer, program counter, write-back value, flag and data address checks
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    pc_even_a: assert property (!prog_counter[0])
        else $error("program counter bit 0 set");
    pc_hold_a: assert property (!busy && !wb_cyc_i |=> $stable(prog_counter))
        else $error("program counter moved while idle");
    we_pulse_a: assert property (dmem_we && clk_en |-> busy ##1 !dmem_we)
        else $error("write strobe outside one execution");
    inc_sum_a: assert property (dmem_we |-> dmem_wdata == dmem_rdata + 8'h01)
        else $error("written value is not operand plus one");
    inc_flags_a: assert property (dmem_we && clk_en |=> zero_flag == (dmem_wdata == 8'h00)
        && carry_flag == (dmem_wdata == 8'h00) && half_byte_flag == (dmem_wdata[3:0] == 4'h0)
        && neg_flag == dmem_wdata[7])
        else $error("flags disagree with written sum");
    addr_hold_a: assert property (!busy |=> busy || $stable(dmem_addr))
        else $error("data address changed without an instruction");

    cover property (dmem_we);
    cover property (!busy ##1 busy);
    cover property ($changed(prog_counter) && busy);
endmodule

bind jump_and_increment_execution exec_asserts i_chk (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .dmem_rdata(dmem_rdata), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_we(dmem_we), .prog_counter(prog_counter), .carry_flag(carry_flag),
    .half_byte_flag(half_byte_flag), .zero_flag(zero_flag), .neg_flag(neg_flag), .busy(busy)
);

// [verif/tb_jump_and_increment_execution.sv]
// Self-checking bench for the jump and add-one execution unit
`timescale 1ns/10ps
module tb_jump_and_increment_execution;
    import exec_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [3:0]  bp = 4'h0;
    logic [7:0]  rdata = 8'h00;
    logic [11:0] daddr;
    logic [7:0]  dwdata;
    logic        dwe;
    logic [20:0] pc;
    logic [7:0]  acc;
    logic        c_f, dc_f, z_f, ov_f, n_f, busy;
    int          err_count = 0;
    int          n_tests = 0;
    int          we_cnt = 0;
    int          cyc_n;
    logic [31:0] q;

    jump_and_increment_execution i_dut (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .bank_pointer(bp), .dmem_rdata(rdata), .dmem_addr(daddr), .dmem_wdata(dwdata), .dmem_we(dwe),
        .prog_counter(pc), .accumulator(acc), .carry_flag(c_f), .half_byte_flag(dc_f), .zero_flag(z_f),
        .arith_wrap_flag(ov_f), .neg_flag(n_f), .busy(busy)
    );

    // Clock and write strobe counter
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (dwe === 1'b1) we_cnt++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic bus cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Waits for the unit to go idle; cyc_n holds the busy cycles seen
    task automatic idle();
        cyc_n = 0;
        do begin
            @(posedge core_clk);
            cyc_n++;
        end while (busy !== 1'b0 && cyc_n < 40);
        cyc_n--;
    endtask

    task automatic add_one(input logic [15:0] op, input logic [7:0] v, input logic [3:0] b);
        @(posedge core_clk);
        rdata <= v; bp <= b; we_cnt = 0;
        wb(1'b1, OFS_INSTR, {16'h0, op});
        idle();
        chk(cyc_n, 4);
    endtask

    task automatic t_reset();
        wb(1'b0, OFS_PC, 0); chk(q, 0);
        wb(1'b0, OFS_ACC, 0); chk(q, 0);
        wb(1'b0, OFS_STATUS, 0); chk(q, 0);
        wb(1'b1, 8'h10, 32'hFFFF_FFFF);
        wb(1'b0, 8'h10, 0); chk(q, 0);
    endtask

    task automatic t_inc_wrap();
        add_one(16'h2A05, 8'hFF, 4'h3);
        chk(daddr, 12'h005);
        chk(dwdata, 8'h00);
        chk(we_cnt, 1);
        chk(acc, 8'h00);
        chk({n_f, ov_f, z_f, dc_f, c_f}, 5'h07);
        wb(1'b0, OFS_STATUS, 0); chk(q, 32'h07);
    endtask

    task automatic t_inc_bank();
        add_one(16'h2990, 8'h7F, 4'h3);
        chk(daddr, 12'h390);
        chk(acc, 8'h80);
        chk(we_cnt, 0);
        chk({n_f, ov_f, z_f, dc_f, c_f}, 5'h1A);
        add_one(16'h2A85, 8'h0F, 4'h3);
        chk(daddr, 12'hF85);
        chk(dwdata, 8'h10);
        chk(acc, 8'h80);
        chk({n_f, ov_f, z_f, dc_f, c_f}, 5'h02);
    endtask

    task automatic far_jump(input logic [19:0] k, input logic [20:0] exp);
        wb(1'b1, OFS_INSTR, {16'h0, FAR_JUMP_W1_OP, k[7:0]});
        wb(1'b0, OFS_STATUS, 0); chk(q[STS_WAIT_HI], 1'b1);
        wb(1'b1, OFS_INSTR, {16'h0, FAR_JUMP_W2_PFX, k[19:8]});
        idle();
        chk(cyc_n, 8);
        chk(pc, exp);
        wb(1'b0, OFS_PC, 0); chk(q, {11'h0, exp});
    endtask

    task automatic t_jump();
        far_jump(20'h01234, 21'h002468);
        far_jump(20'hFFFFF, 21'h1FFFFE);
        far_jump(20'h00000, 21'h000000);
    endtask

    task automatic t_refuse();
        far_jump(20'h80001, 21'h100002);
        wb(1'b1, OFS_INSTR, {16'h0, FAR_JUMP_W1_OP, 8'h56});
        wb(1'b1, OFS_INSTR, 32'h0000_E012);
        idle();
        chk(pc, 21'h100002);
        wb(1'b0, OFS_STATUS, 0); chk(q[STS_REFUSED], 1'b1);
        wb(1'b1, OFS_STATUS, 32'h80);
        wb(1'b0, OFS_STATUS, 0); chk(q, 0);
    endtask

    // Instruction written while another executes is dropped and flagged
    task automatic t_busy_drop();
        @(posedge core_clk);
        rdata <= 8'h41;
        we_cnt = 0;
        wb(1'b1, OFS_INSTR, 32'h0000_2805);
        wb(1'b1, OFS_INSTR, 32'h0000_2A05);
        idle();
        chk(acc, 8'h42);
        chk(we_cnt, 0);
        wb(1'b0, OFS_STATUS, 0);
        chk(q, 32'h80);
        wb(1'b1, OFS_STATUS, 32'h80);
        wb(1'b0, OFS_STATUS, 0);
        chk(q, 0);
    endtask

    // Clock enable low freezes an add-one in flight
    task automatic t_freeze();
        wb(1'b1, OFS_ACC, 32'h5A);
        wb(1'b0, OFS_ACC, 0);
        chk(q, 32'h5A);
        @(posedge core_clk);
        rdata <= 8'h09;
        wb(1'b1, OFS_INSTR, 32'h0000_2810);
        clk_en <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk(busy, 1'b1);
        chk(acc, 8'h5A);
        clk_en <= 1'b1;
        idle();
        chk(cyc_n, 4);
        chk(acc, 8'h0A);
        chk(daddr, 12'h010);
        chk({n_f, ov_f, z_f, dc_f, c_f}, 5'h00);
    endtask

    task automatic results();
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the few hundred cycles the tests need
    initial begin
        #200000;
        err_count++;
        results();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_inc_wrap();
        t_inc_bank();
        t_jump();
        t_refuse();
        t_busy_drop();
        t_freeze();
        results();
    end
endmodule
